/* File: hdl/l1c_pkg.sv */
// Behaviour
// R01: Cache policy is write-back after hard reset until software selects otherwise.
// R02: Setting the write policy select bit switches the cache to write-through.
// R03: Software should flush the cache when moving from write-back to write-through.
// R04: Both configuration bits set disables fills, write-throughs and invalidations.
// R05: Fill-disable alone suppresses fills; write-throughs and invalidations continue.
// R06: Loading fill-disable 0 with not-write-through 1 raises protection fault, code zero.
// R07: Both configuration bits clear enables fills, write-throughs and invalidations.
// R08: With paging on, page bits give per-access cacheability and write policy.
// R09: Write-back only when the select bit says so; otherwise page write-back is write-through.
// R10: Expansion-bus and PCI accesses are never allocated; only cacheable memory or ROM.
// R11: Cache is one unified 16-kilobyte store for code and data.
// R12: Core runs at 100 or 133 MHz behind a 33 MHz bus interface.
// R13: No second-level cache control and no pins for one.
// R14: System management mode is not implemented and cannot be entered.
// R15: Identify instruction always reports write-back, whatever the control register says.
// R16: Processor control register holds write policy select and core clock speed select.
// R17: Write to the floating point error clear port clears the pending error interrupt.
// R18: Reset status records a soft reset caused by a processor shutdown cycle.
// R19: On a speed change, flush the cache and wait before altering the PLL select.
// R20: Cacheable only if region, page and clear fill-disable all allow; any denial blocks.
package l1c_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [11:0] OFS_CHIP_REVISION_ID = 12'h000;
   localparam logic [11:0] OFS_PROCESSOR_CONTROL = 12'h002;
   localparam logic [11:0] OFS_FP_ERROR_IRQ_MAPPING = 12'hd46;
   localparam logic [11:0] OFS_RESET_SOURCE_STATUS = 12'hd74;
   localparam logic [11:0] IO_HOST_CTRL_DATA_PORT = 12'h060;
   localparam logic [11:0] IO_HOST_CTRL_COMMAND_PORT = 12'h064;
   localparam logic [11:0] IO_SYSTEM_CONTROL_PORT_A = 12'h092;
   localparam logic [11:0] IO_FP_ERROR_IRQ_CLEAR = 12'h0f0;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int CTL_SPEED_BIT = 0;
   localparam int CTL_WR_MODE_BIT = 4;
   localparam int RST_SHUTDOWN_BIT = 0;
   localparam int PORTA_CPU_RST_BIT = 0;
   localparam int PORTA_A20_BIT = 1;
   localparam int HOST_DATA_A20_BIT = 1;
   // ****************************************
   // Reset values and command codes
   // ****************************************
   localparam logic [7:0] RST_PROCESSOR_CONTROL = 8'h00;
   localparam logic [7:0] RST_FP_ERROR_IRQ_MAPPING = 8'h00;
   localparam logic [7:0] RST_RESET_SOURCE_STATUS = 8'h00;
   localparam logic [7:0] RST_SYSTEM_CONTROL_PORT_A = 8'h00;
   localparam logic [7:0] CMD_A20_WRITE = 8'hd1;
   localparam logic [7:0] CMD_CPU_RESET = 8'hfe;
   // ****************************************
   // Sizes, timing and fault code
   // ****************************************
   localparam int CACHE_KBYTES = 16;
   localparam int CORE_MHZ_LOW = 100;
   localparam int CORE_MHZ_HIGH = 133;
   localparam int BUS_MHZ = 33;
   localparam int CLK_MHZ = 250;
   localparam int PLL_SETTLE_US = 1000;
   localparam int PLL_SETTLE_CYCLES = PLL_SETTLE_US * CLK_MHZ;
   localparam int SOFT_RESET_CYCLES = 16;
   localparam logic [15:0] GP_FAULT_CODE = 16'h0000;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [3:0] {
      L1C_RUN = 4'b0001,
      L1C_FLUSH = 4'b0010,
      L1C_WAIT = 4'b0100,
      L1C_SETTLE = 4'b1000
   } l1c_speed_state_t;
   typedef enum logic [1:0] {
      L1C_REGION_MEM = 2'h0,
      L1C_REGION_ROM = 2'h1,
      L1C_REGION_GPBUS = 2'h2,
      L1C_REGION_PCI = 2'h3
   } l1c_region_t;
endpackage

/* File: hdl/l1c_ctl_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface l1c_ctl_if;
   logic fill_disable;
   logic not_write_through;
   logic policy_through;
   logic fill_en;
   logic write_through_en;
   logic inval_en;
   logic gp_fault;
   modport decoder (input fill_disable, not_write_through, policy_through,
      output fill_en, write_through_en, inval_en, gp_fault);
   modport user (output fill_disable, not_write_through, policy_through,
      input fill_en, write_through_en, inval_en, gp_fault);
endinterface
`default_nettype wire

/* File: hdl/l1c_mode_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module l1c_mode_decode (
   l1c_ctl_if.decoder ctl
);
   // ****************************************
   // Configuration bit decode
   // ****************************************
   wire both_set = ctl.fill_disable & ctl.not_write_through;
   wire only_fd = ctl.fill_disable & ~ctl.not_write_through;
   wire illegal = ~ctl.fill_disable & ctl.not_write_through;
   assign ctl.fill_en = ~ctl.fill_disable & ~ctl.not_write_through; // R07
   assign ctl.write_through_en = ~both_set & ~illegal; // R04 R05
   assign ctl.inval_en = ~both_set & ~illegal; // R04 R05
   assign ctl.gp_fault = illegal; // R06
   wire unused_only_fd = only_fd & ctl.policy_through;
endmodule
`default_nettype wire

/* File: hdl/l1c_cache_mode_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module l1c_cache_mode_ctrl #(
   parameter int SETTLE_CYCLES = l1c_pkg::PLL_SETTLE_CYCLES,
   parameter logic [15:0] REVISION_ID = 16'h0001 // Arbitrary value
) (
   input wire logic MCLK_IN,
   input wire logic RESETN_IN,
   // Register port: memory-mapped and I/O-mapped
   input wire logic MEM_WR_IN,
   input wire logic MEM_RD_IN,
   input wire logic IO_WR_IN,
   input wire logic IO_RD_IN,
   input wire logic [11:0] ADDR_IN,
   input wire logic [15:0] WDATA_IN,
   output logic [15:0] RDATA_OUT,
   // Machine status register load from the core
   input wire logic MSR_LOAD_IN,
   input wire logic FILL_DISABLE_IN,
   input wire logic NOT_WRITE_THROUGH_IN,
   // Per-access attributes
   input wire logic ACC_VALID_IN,
   input wire logic PAGING_IN,
   input wire logic PAGE_CACHE_DISABLE_IN,
   input wire logic PAGE_WRITE_THROUGH_IN,
   input wire l1c_pkg::l1c_region_t REGION_IN,
   input wire logic REGION_CACHEABLE_IN,
   // Events
   input wire logic FLUSH_DONE_IN,
   input wire logic SHUTDOWN_IN,
   input wire logic FP_ERROR_IN,
   // Outputs
   output logic ACC_ALLOCATE_OUT,
   output logic ACC_WRITE_THROUGH_OUT,
   output logic FILL_EN_OUT,
   output logic WRITE_THROUGH_EN_OUT,
   output logic INVAL_EN_OUT,
   output logic GP_FAULT_OUT,
   output logic [15:0] GP_FAULT_CODE_OUT,
   output logic ID_WRITE_BACK_OUT,
   output logic FLUSH_REQ_OUT,
   output logic PLL_SPEED_SEL_OUT,
   output logic CORE_STALL_OUT,
   output logic FP_ERROR_IRQ_OUT,
   output logic SOFT_RESET_OUT,
   output logic A20_GATE_OUT,
   output logic SMM_ENTRY_OUT
);
   import l1c_pkg::*;

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
      end else begin
         sync_a <= {SHUTDOWN_IN, FP_ERROR_IN, FLUSH_DONE_IN};
         sync_b <= sync_a;
      end
   end
   wire flush_done = sync_b[0];
   wire fp_err = sync_b[1];
   wire shutdown = sync_b[2];
   logic shutdown_prev;

   // ****************************************
   // Register state
   // ****************************************
   logic [7:0] processor_control;
   logic [7:0] fp_error_irq_mapping;
   logic [7:0] reset_source_status;
   logic [7:0] system_control_port_a;
   logic a20_host;
   logic cmd_a20_pending;
   logic fill_disable;
   logic not_write_through;
   logic fp_pending;
   logic [4:0] sreset_cnt;
   logic applied_speed;
   l1c_speed_state_t state;
   logic [31:0] settle_cnt;

   // ****************************************
   // Address decode
   // ****************************************
   wire wr_ctl = MEM_WR_IN && ADDR_IN == OFS_PROCESSOR_CONTROL;
   wire wr_map = MEM_WR_IN && ADDR_IN == OFS_FP_ERROR_IRQ_MAPPING;
   wire wr_rst = MEM_WR_IN && ADDR_IN == OFS_RESET_SOURCE_STATUS;
   wire wr_data = IO_WR_IN && ADDR_IN == IO_HOST_CTRL_DATA_PORT;
   wire wr_cmd = IO_WR_IN && ADDR_IN == IO_HOST_CTRL_COMMAND_PORT;
   wire wr_porta = IO_WR_IN && ADDR_IN == IO_SYSTEM_CONTROL_PORT_A;
   wire wr_fpclr = IO_WR_IN && ADDR_IN == IO_FP_ERROR_IRQ_CLEAR;
   wire [7:0] wbyte = WDATA_IN[7:0];
   wire shutdown_evt = shutdown & ~shutdown_prev;
   wire cmd_reset = wr_cmd && wbyte == CMD_CPU_RESET;
   wire porta_rst_rise = wr_porta & wbyte[PORTA_CPU_RST_BIT]
      & ~system_control_port_a[PORTA_CPU_RST_BIT];
   wire soft_evt = shutdown_evt | cmd_reset | porta_rst_rise;

   function automatic logic [15:0] rd_mux(input logic mem, input logic [11:0] a);
      logic [15:0] v;
      v = 16'h0000;
      if (mem) begin
         unique case (a)
            OFS_CHIP_REVISION_ID: v = REVISION_ID;
            OFS_PROCESSOR_CONTROL: v = {8'h00, processor_control};
            OFS_FP_ERROR_IRQ_MAPPING: v = {8'h00, fp_error_irq_mapping};
            OFS_RESET_SOURCE_STATUS: v = {8'h00, reset_source_status};
            default: v = 16'h0000;
         endcase
      end else if (a == IO_SYSTEM_CONTROL_PORT_A) begin
         v = {8'h00, system_control_port_a};
      end
      return v;
   endfunction
   wire [15:0] next_rdata = (MEM_RD_IN | IO_RD_IN) ? rd_mux(MEM_RD_IN, ADDR_IN) : 16'h0000;

   // ****************************************
   // Control and status registers
   // ****************************************
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         processor_control <= RST_PROCESSOR_CONTROL; // R01
         fp_error_irq_mapping <= RST_FP_ERROR_IRQ_MAPPING;
         system_control_port_a <= RST_SYSTEM_CONTROL_PORT_A;
      end else begin
         if (wr_ctl) begin
            processor_control <= wbyte; // R02 R16
         end
         if (wr_map) begin
            fp_error_irq_mapping <= wbyte;
         end
         if (wr_porta) begin
            system_control_port_a <= wbyte;
         end
      end
   end

   // Set wins over write-one-to-clear
   wire [7:0] rst_set = 8'(shutdown_evt) << RST_SHUTDOWN_BIT;
   wire [7:0] rst_clr = wr_rst ? wbyte : 8'h00;
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         reset_source_status <= RST_RESET_SOURCE_STATUS;
         shutdown_prev <= 1'b0;
      end else begin
         reset_source_status <= (reset_source_status & ~rst_clr) | rst_set; // R18
         shutdown_prev <= shutdown;
      end
   end

   // Pending error survives a clear in the same cycle
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         fp_pending <= 1'b0;
      end else begin
         fp_pending <= fp_err | (fp_pending & ~wr_fpclr); // R17
      end
   end

   // ****************************************
   // Gate control for address line 20
   // ****************************************
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         cmd_a20_pending <= 1'b0;
         a20_host <= 1'b0;
      end else begin
         if (wr_cmd) begin
            cmd_a20_pending <= wbyte == CMD_A20_WRITE;
         end else if (wr_data) begin
            cmd_a20_pending <= 1'b0;
         end
         if (wr_data && cmd_a20_pending) begin
            a20_host <= wbyte[HOST_DATA_A20_BIT];
         end
      end
   end

   // ****************************************
   // Soft reset pulse stretcher
   // ****************************************
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         sreset_cnt <= 5'h00;
      end else if (soft_evt) begin
         sreset_cnt <= 5'(SOFT_RESET_CYCLES);
      end else if (sreset_cnt != 5'h00) begin
         sreset_cnt <= sreset_cnt - 5'h01;
      end
   end

   // ****************************************
   // Machine status configuration bits
   // ****************************************
   // Illegal combination is refused and leaves the old bits
   wire msr_illegal = ~FILL_DISABLE_IN & NOT_WRITE_THROUGH_IN;
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         fill_disable <= 1'b1;
         not_write_through <= 1'b1;
      end else if (MSR_LOAD_IN && !msr_illegal) begin
         fill_disable <= FILL_DISABLE_IN;
         not_write_through <= NOT_WRITE_THROUGH_IN;
      end
   end

   l1c_ctl_if ctl ();
   assign ctl.fill_disable = fill_disable;
   assign ctl.not_write_through = not_write_through;
   assign ctl.policy_through = processor_control[CTL_WR_MODE_BIT];
   l1c_mode_decode u_decode (
      .ctl(ctl)
   );

   // ****************************************
   // Core speed change sequence
   // ****************************************
   wire req_speed = processor_control[CTL_SPEED_BIT];
   wire settle_done = settle_cnt == 32'(SETTLE_CYCLES - 1);
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         state <= L1C_RUN;
         applied_speed <= 1'b0;
         settle_cnt <= 32'h0;
      end else begin
         unique case (state)
            L1C_RUN: begin
               if (req_speed != applied_speed) begin
                  state <= L1C_FLUSH; // R19
               end
            end
            L1C_FLUSH: begin
               state <= L1C_WAIT;
            end
            L1C_WAIT: begin
               if (flush_done) begin
                  applied_speed <= req_speed; // R19
                  settle_cnt <= 32'h0;
                  state <= L1C_SETTLE;
               end
            end
            L1C_SETTLE: begin
               settle_cnt <= settle_cnt + 32'h1;
               if (settle_done) begin
                  state <= L1C_RUN;
               end
            end
         endcase
      end
   end
   wire changing = state != L1C_RUN;

   // ****************************************
   // Per-access policy
   // ****************************************
   wire region_ok = REGION_CACHEABLE_IN
      && (REGION_IN == L1C_REGION_MEM || REGION_IN == L1C_REGION_ROM); // R10
   wire page_ok = ~(PAGING_IN & PAGE_CACHE_DISABLE_IN); // R08
   wire next_alloc = ACC_VALID_IN & region_ok & page_ok & ctl.fill_en & ~changing; // R20
   wire next_wt = processor_control[CTL_WR_MODE_BIT]
      | (PAGING_IN & PAGE_WRITE_THROUGH_IN); // R09

   // ****************************************
   // Output registers
   // ****************************************
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         RDATA_OUT <= 16'h0000;
         ACC_ALLOCATE_OUT <= 1'b0;
         ACC_WRITE_THROUGH_OUT <= 1'b0;
         FILL_EN_OUT <= 1'b0;
         WRITE_THROUGH_EN_OUT <= 1'b0;
         INVAL_EN_OUT <= 1'b0;
         GP_FAULT_OUT <= 1'b0;
         GP_FAULT_CODE_OUT <= GP_FAULT_CODE;
         ID_WRITE_BACK_OUT <= 1'b1;
         FLUSH_REQ_OUT <= 1'b0;
         PLL_SPEED_SEL_OUT <= 1'b0;
         CORE_STALL_OUT <= 1'b0;
         FP_ERROR_IRQ_OUT <= 1'b0;
         SOFT_RESET_OUT <= 1'b0;
         A20_GATE_OUT <= 1'b0;
         SMM_ENTRY_OUT <= 1'b0;
      end else begin
         RDATA_OUT <= next_rdata;
         ACC_ALLOCATE_OUT <= next_alloc; // R20
         ACC_WRITE_THROUGH_OUT <= ACC_VALID_IN & next_wt; // R09
         FILL_EN_OUT <= ctl.fill_en & ~changing;
         WRITE_THROUGH_EN_OUT <= ctl.write_through_en; // R04 R05 R07
         INVAL_EN_OUT <= ctl.inval_en;
         GP_FAULT_OUT <= MSR_LOAD_IN & msr_illegal; // R06
         GP_FAULT_CODE_OUT <= GP_FAULT_CODE;
         ID_WRITE_BACK_OUT <= 1'b1; // R15
         FLUSH_REQ_OUT <= state == L1C_FLUSH;
         PLL_SPEED_SEL_OUT <= applied_speed; // R12
         CORE_STALL_OUT <= state == L1C_SETTLE;
         FP_ERROR_IRQ_OUT <= fp_pending;
         SOFT_RESET_OUT <= soft_evt | (sreset_cnt > 5'h01);
         A20_GATE_OUT <= a20_host | system_control_port_a[PORTA_A20_BIT];
         SMM_ENTRY_OUT <= 1'b0; // R14
      end
   end
   // Single unified store, no second-level port R11 R13
endmodule
`default_nettype wire

/* File: verification/l1c_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
module l1c_core_model (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] delay_in,
   input wire logic flush_req_in,
   output logic flush_done_out
);
   logic [7:0] cnt;
   logic busy;
   // ****************************************
   // Flush engine: delay, then done for 4 cycles
   // ****************************************
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         busy <= 1'b0;
         cnt <= 8'h00;
         flush_done_out <= 1'b0;
      end else if (flush_req_in) begin
         busy <= 1'b1;
         cnt <= delay_in;
      end else if (cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
      end else if (busy) begin
         busy <= 1'b0;
         flush_done_out <= 1'b1;
         cnt <= 8'h03;
      end else begin
         flush_done_out <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: verification/l1c_cache_mode_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module l1c_cache_mode_chk #(
   parameter int SETTLE_CYCLES = 8
) (
   input wire logic MCLK_IN,
   input wire logic RESETN_IN,
   input wire logic MSR_LOAD_IN,
   input wire logic FILL_DISABLE_IN,
   input wire logic NOT_WRITE_THROUGH_IN,
   input wire logic ACC_VALID_IN,
   input wire logic PAGING_IN,
   input wire logic PAGE_CACHE_DISABLE_IN,
   input wire logic PAGE_WRITE_THROUGH_IN,
   input wire l1c_pkg::l1c_region_t REGION_IN,
   input wire logic REGION_CACHEABLE_IN,
   input wire logic ACC_ALLOCATE_OUT,
   input wire logic ACC_WRITE_THROUGH_OUT,
   input wire logic FILL_EN_OUT,
   input wire logic WRITE_THROUGH_EN_OUT,
   input wire logic INVAL_EN_OUT,
   input wire logic GP_FAULT_OUT,
   input wire logic [15:0] GP_FAULT_CODE_OUT,
   input wire logic ID_WRITE_BACK_OUT,
   input wire logic SMM_ENTRY_OUT,
   input wire logic FLUSH_REQ_OUT,
   input wire logic PLL_SPEED_SEL_OUT,
   input wire logic CORE_STALL_OUT
);
   import l1c_pkg::*;
   localparam int STALL_MAX = SETTLE_CYCLES + 4;
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!RESETN_IN);
   // ****************************************
   // Checks
   // ****************************************
   a_gp_raise: assert property (
      MSR_LOAD_IN && !FILL_DISABLE_IN && NOT_WRITE_THROUGH_IN |=> GP_FAULT_OUT)
      else $error("gp fault missing");
   a_gp_legal: assert property (
      MSR_LOAD_IN && (FILL_DISABLE_IN || !NOT_WRITE_THROUGH_IN) |=> !GP_FAULT_OUT)
      else $error("gp fault on legal load");
   a_fault_code: assert property (GP_FAULT_OUT |-> GP_FAULT_CODE_OUT == GP_FAULT_CODE)
      else $error("gp fault code not zero");
   a_wt_inval: assert property (WRITE_THROUGH_EN_OUT == INVAL_EN_OUT)
      else $error("write-through and invalidate enables differ");
   a_fill_off: assert property (MSR_LOAD_IN && FILL_DISABLE_IN |-> ##[1:2] !FILL_EN_OUT)
      else $error("fill still enabled");
   a_fill_on: assert property (
      MSR_LOAD_IN && !FILL_DISABLE_IN && !NOT_WRITE_THROUGH_IN |-> ##[1:2] FILL_EN_OUT)
      else $error("fill not enabled");
   a_alloc_bus: assert property (
      ACC_VALID_IN && REGION_IN inside {L1C_REGION_GPBUS, L1C_REGION_PCI} |=> !ACC_ALLOCATE_OUT)
      else $error("bus access allocated");
   a_alloc_deny: assert property (ACC_VALID_IN && (PAGING_IN && PAGE_CACHE_DISABLE_IN ||
      !REGION_CACHEABLE_IN) |=> !ACC_ALLOCATE_OUT) else $error("denied access allocated");
   a_page_wt: assert property (
      ACC_VALID_IN && PAGING_IN && PAGE_WRITE_THROUGH_IN |=> ACC_WRITE_THROUGH_OUT)
      else $error("page write-through lost");
   a_id_smm: assert property (ID_WRITE_BACK_OUT && !SMM_ENTRY_OUT)
      else $error("identify or smm output wrong");
   a_flush_first: assert property (
      $rose(FLUSH_REQ_OUT) |=> $stable(PLL_SPEED_SEL_OUT) [*2])
      else $error("pll changed before flush done");
   a_flush_pulse: assert property (FLUSH_REQ_OUT |=> !FLUSH_REQ_OUT)
      else $error("flush request too long");
   a_stall_pll: assert property ($changed(PLL_SPEED_SEL_OUT) |-> ##[0:1] CORE_STALL_OUT)
      else $error("no stall on pll change");
   a_stall_end: assert property ($rose(CORE_STALL_OUT) |-> ##[1:STALL_MAX] !CORE_STALL_OUT)
      else $error("stall too long");
   c_gp: cover property (GP_FAULT_OUT);
   c_alloc: cover property (ACC_ALLOCATE_OUT && ACC_WRITE_THROUGH_OUT);
   c_pll: cover property ($rose(PLL_SPEED_SEL_OUT));
endmodule
`default_nettype wire

/* File: verification/tb_l1c_cache_mode_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_l1c_cache_mode_ctrl;
   import l1c_pkg::*;
   localparam int SETTLE = 8;
   localparam logic [15:0] REV = 16'h5a3c; // Arbitrary value
   logic clk = 1'b0, rstn = 1'b0, mem_wr = 1'b0, mem_rd = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
   logic msr_ld = 1'b0, fd = 1'b1, nwt = 1'b1, acc_v = 1'b0, pg = 1'b0, pcd = 1'b0, pwt = 1'b0;
   logic cach = 1'b0, shut = 1'b0, fpe = 1'b0, rd_q = 1'b0, acc_q = 1'b0, fen = 1'b0, wtb = 1'b0;
   logic fl_done, alloc, awt, fill_en, wt_en, inv_en, gpf, idwb, flreq, pll, stall, fpirq, system_management_mode;
   logic srst, a20;
   logic [11:0] addr = 12'h000;
   logic [15:0] wdata = 16'h0000, rdata, gpcode;
   logic [7:0] dly = 8'h14;
   l1c_region_t region = L1C_REGION_MEM;
   logic [15:0] exp_rd[$], exp_acc[$];
   logic [1:0] cfg[4] = '{2'b10, 2'b00, 2'b01, 2'b11};
   logic [2:0] ens[4] = '{3'b011, 3'b111, 3'b111, 3'b000};
   int errors = 0, num_checks = 0, seed = 42886;
   always #2 clk = ~clk;
   l1c_cache_mode_ctrl #(.SETTLE_CYCLES(SETTLE), .REVISION_ID(REV)) dut (
      .MCLK_IN(clk), .RESETN_IN(rstn), .MEM_WR_IN(mem_wr), .MEM_RD_IN(mem_rd),
      .IO_WR_IN(io_wr), .IO_RD_IN(io_rd), .ADDR_IN(addr), .WDATA_IN(wdata), .RDATA_OUT(rdata),
      .MSR_LOAD_IN(msr_ld), .FILL_DISABLE_IN(fd), .NOT_WRITE_THROUGH_IN(nwt),
      .ACC_VALID_IN(acc_v), .PAGING_IN(pg), .PAGE_CACHE_DISABLE_IN(pcd),
      .PAGE_WRITE_THROUGH_IN(pwt), .REGION_IN(region), .REGION_CACHEABLE_IN(cach),
      .FLUSH_DONE_IN(fl_done), .SHUTDOWN_IN(shut), .FP_ERROR_IN(fpe),
      .ACC_ALLOCATE_OUT(alloc), .ACC_WRITE_THROUGH_OUT(awt), .FILL_EN_OUT(fill_en),
      .WRITE_THROUGH_EN_OUT(wt_en), .INVAL_EN_OUT(inv_en), .GP_FAULT_OUT(gpf),
      .GP_FAULT_CODE_OUT(gpcode), .ID_WRITE_BACK_OUT(idwb), .FLUSH_REQ_OUT(flreq),
      .PLL_SPEED_SEL_OUT(pll), .CORE_STALL_OUT(stall), .FP_ERROR_IRQ_OUT(fpirq),
      .SOFT_RESET_OUT(srst), .A20_GATE_OUT(a20), .SMM_ENTRY_OUT(system_management_mode));
   l1c_core_model core (.clk_in(clk), .rstn_in(rstn), .delay_in(dly), .flush_req_in(flreq),
      .flush_done_out(fl_done));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
      num_checks++;
      if (s !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cmp_bit(input string n, input logic e, input logic s);
      cmp(n, {15'h0000, e}, {15'h0000, s});
   endtask
   task automatic rd(input logic m, input logic [11:0] a, input logic [15:0] e);
      @(negedge clk);
      {mem_rd, io_rd, addr} = {m, !m, a};
      exp_rd.push_back(e);
      @(negedge clk);
      {mem_rd, io_rd} = 2'b00;
   endtask
   task automatic wr(input logic m, input logic [11:0] a, input logic [15:0] d);
      @(negedge clk);
      {mem_wr, io_wr, addr, wdata} = {m, !m, a, d};
      @(negedge clk);
      {mem_wr, io_wr} = 2'b00;
   endtask
   task automatic msr(input logic f, input logic n, input logic g, input logic [2:0] e);
      @(negedge clk);
      {msr_ld, fd, nwt} = {1'b1, f, n};
      @(negedge clk);
      msr_ld = 1'b0;
      cmp_bit("gp_fault", g, gpf);
      repeat (3) @(negedge clk);
      cmp("enables", {13'h0000, e}, {13'h0000, fill_en, wt_en, inv_en});
   endtask
   task automatic acc(input int n);
      logic [31:0] r;
      for (int j = 0; j < n; j++) begin
         @(negedge clk);
         r = $random(seed);
         {pg, pcd, pwt, cach} = r[3:0];
         region = l1c_region_t'(r[5:4]);
         acc_v = 1'b1;
         exp_acc.push_back({14'h0000, region < L1C_REGION_GPBUS && cach && !(pg && pcd) && fen,
            wtb | (pg & pwt)});
      end
      @(negedge clk);
      acc_v = 1'b0;
   endtask
   task automatic wait_pll(input logic v);
      for (int k = 0; k < 200 && pll !== v; k++) @(negedge clk);
      cmp_bit("pll_sel", v, pll);
      for (int k = 0; k < 50 && stall !== 1'b0; k++) @(negedge clk);
      cmp_bit("stall", 1'b0, stall);
   endtask
   task automatic print_verdict();
      $display("Checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ****************************************
   // Result monitor
   // ****************************************
   always @(posedge clk) begin
      rd_q <= mem_rd | io_rd;
      acc_q <= acc_v;
   end
   always @(negedge clk) begin
      if (rd_q)
         cmp("read_data", exp_rd.pop_front(), rdata);
      if (acc_q)
         cmp("access", exp_acc.pop_front(), {14'h0000, alloc, awt});
   end
   // ****************************************
   // Stimulus
   // ****************************************
   initial begin
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      cmp_bit("fill_en", 1'b0, fill_en);
      cmp_bit("id_wb", 1'b1, idwb);
      cmp_bit("smm", 1'b0, system_management_mode);
      cmp("fault_code", GP_FAULT_CODE, gpcode);
      rd(1'b1, OFS_PROCESSOR_CONTROL, RST_PROCESSOR_CONTROL);
      wr(1'b1, OFS_CHIP_REVISION_ID, 16'hffff);
      rd(1'b1, OFS_CHIP_REVISION_ID, REV);
      rd(1'b1, 12'h010, 16'h0000);
      for (int i = 0; i < 4; i++) msr(cfg[i][1], cfg[i][0], cfg[i] == 2'b01, ens[i]);
      msr(1'b0, 1'b0, 1'b0, 3'b111);
      fen = 1'b1;
      acc(16);
      wr(1'b1, OFS_PROCESSOR_CONTROL, 16'h0010);
      wtb = 1'b1;
      rd(1'b1, OFS_PROCESSOR_CONTROL, 16'h0010);
      acc(16);
      msr(1'b1, 1'b0, 1'b0, 3'b011);
      fen = 1'b0;
      acc(8);
      msr(1'b0, 1'b0, 1'b0, 3'b111);
      fen = 1'b1;
      wr(1'b1, OFS_PROCESSOR_CONTROL, 16'h0011);
      wait_pll(1'b1);
      rd(1'b1, OFS_PROCESSOR_CONTROL, 16'h0011);
      dly = 8'h01;
      wr(1'b1, OFS_PROCESSOR_CONTROL, 16'h0010);
      wait_pll(1'b0);
      acc(8);
      shut = 1'b1;
      repeat (4) @(negedge clk);
      cmp_bit("soft_reset", 1'b1, srst);
      shut = 1'b0;
      repeat (3) @(negedge clk);
      rd(1'b1, OFS_RESET_SOURCE_STATUS, 16'h0001);
      wr(1'b1, OFS_RESET_SOURCE_STATUS, 16'h0001);
      rd(1'b1, OFS_RESET_SOURCE_STATUS, 16'h0000);
      fpe = 1'b1;
      repeat (6) @(negedge clk);
      cmp_bit("fp_irq", 1'b1, fpirq);
      fpe = 1'b0;
      // Let the synchronised error drop, else the set beats the clear
      repeat (2) @(negedge clk);
      wr(1'b0, IO_FP_ERROR_IRQ_CLEAR, 16'h0000);
      @(negedge clk);
      cmp_bit("fp_irq", 1'b0, fpirq);
      wr(1'b0, IO_SYSTEM_CONTROL_PORT_A, 16'h0002);
      rd(1'b0, IO_SYSTEM_CONTROL_PORT_A, 16'h0002);
      cmp_bit("a20", 1'b1, a20);
      repeat (4) @(negedge clk);
      print_verdict();
   end
   initial begin
      #(4 * 5000);
      errors++;
      print_verdict();
   end
endmodule
bind l1c_cache_mode_ctrl l1c_cache_mode_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk (
   .MCLK_IN(MCLK_IN), .RESETN_IN(RESETN_IN), .MSR_LOAD_IN(MSR_LOAD_IN),
   .FILL_DISABLE_IN(FILL_DISABLE_IN), .NOT_WRITE_THROUGH_IN(NOT_WRITE_THROUGH_IN),
   .ACC_VALID_IN(ACC_VALID_IN), .PAGING_IN(PAGING_IN),
   .PAGE_CACHE_DISABLE_IN(PAGE_CACHE_DISABLE_IN), .PAGE_WRITE_THROUGH_IN(PAGE_WRITE_THROUGH_IN),
   .REGION_IN(REGION_IN), .REGION_CACHEABLE_IN(REGION_CACHEABLE_IN),
   .ACC_ALLOCATE_OUT(ACC_ALLOCATE_OUT), .ACC_WRITE_THROUGH_OUT(ACC_WRITE_THROUGH_OUT),
   .FILL_EN_OUT(FILL_EN_OUT), .WRITE_THROUGH_EN_OUT(WRITE_THROUGH_EN_OUT),
   .INVAL_EN_OUT(INVAL_EN_OUT), .GP_FAULT_OUT(GP_FAULT_OUT), .GP_FAULT_CODE_OUT(GP_FAULT_CODE_OUT),
   .ID_WRITE_BACK_OUT(ID_WRITE_BACK_OUT), .SMM_ENTRY_OUT(SMM_ENTRY_OUT),
   .FLUSH_REQ_OUT(FLUSH_REQ_OUT), .PLL_SPEED_SEL_OUT(PLL_SPEED_SEL_OUT),
   .CORE_STALL_OUT(CORE_STALL_OUT));
`default_nettype wire
